// ==== src/tpm_top.sv ====
`timescale 1ns/1ps
// =========================================================
// transfer outputs and power-on behaviour
module tpm_top import tpm_pkg::*; (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   input wire logic signed [15:0] pv,
   input wire logic signed [15:0] internal_target,
   input wire logic signed [15:0] local_sp,
   input wire logic signed [15:0] remote_sp,
   input wire logic signed [15:0] mv_heat,
   input wire logic signed [15:0] mv_cool,
   input wire logic event_run_pin,
   input wire logic [1:0] nv_power_on_mode,
   input wire logic retained_run,
   input wire logic retained_manual,
   input wire logic [15:0] retained_mv,
   output logic [15:0] out1_current_ua,
   output logic [15:0] out2_current_ua,
   output logic run_state,
   output logic manual_state,
   output logic [15:0] mv_value
);
   // =========================================================
   // configuration registers
   logic [7:0] out_sel_reg; // source and range of both outputs
   logic [15:0] scale_hi_reg [2]; // upper scaling limits
   logic [15:0] scale_lo_reg [2]; // lower scaling limits
   logic [3:0] point_reg; // scaling_point_position, display only
   logic [1:0] cfg_mode_reg; // power-on selector as written
   logic onoff_reg; // control method: 1 = on/off
   logic [15:0] mv_stop_reg; // MV used when stopped
   logic [1:0] active_mode_reg; // selector in force since restart

   // =========================================================
   // operating state
   tpm_state_t state_reg;
   logic run_reg;
   logic manual_reg;
   logic [15:0] mv_reg;
   logic boot_reg; // restart came from power-up
   logic apply_reg; // one-cycle strobe to the decision table

   // =========================================================
   // event input synchroniser
   logic ev_s1_reg; // first stage, read only by second
   logic ev_s2_reg;
   logic ev_s3_reg; // previous value for edge detect
   logic ev_rise;
   logic ev_fall;

   // decoded write strobes
   logic cmd_wr;
   logic cmd_run;
   logic cmd_stop;
   logic soft_reset;

   // decision table results
   logic init_valid;
   logic init_run;
   logic init_manual;
   logic [15:0] init_mv;

   // per output selected source
   logic signed [15:0] src_val [2];
   logic [15:0] cur_ua [2];

   assign cmd_wr = wr_en && (addr == TPM_ADDR_CMD);
   assign cmd_run = cmd_wr && wdata[TPM_CMD_RUN];
   assign cmd_stop = cmd_wr && wdata[TPM_CMD_STOP];
   assign soft_reset = cmd_wr && wdata[TPM_CMD_SOFT_RESET];
   assign ev_rise = ev_s2_reg && !ev_s3_reg;
   assign ev_fall = !ev_s2_reg && ev_s3_reg;

   // =========================================================
   // two-stage synchroniser plus edge history for the pin
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ev_s1_reg <= 1'b0;
         ev_s2_reg <= 1'b0;
         ev_s3_reg <= 1'b0;
      end else begin
         ev_s1_reg <= event_run_pin;
         ev_s2_reg <= ev_s1_reg;
         ev_s3_reg <= ev_s2_reg;
      end
   end

   // =========================================================
   // output assignment and scaling registers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_sel_reg <= 8'h00;
         scale_hi_reg[0] <= TPM_SCALE_HI_RST;
         scale_hi_reg[1] <= TPM_SCALE_HI_RST;
         scale_lo_reg[0] <= TPM_SCALE_LO_RST;
         scale_lo_reg[1] <= TPM_SCALE_LO_RST;
         point_reg <= 4'h0;
      end else if (wr_en) begin
         // scaling changes are meant for a stopped unit only; these writes are accepted while running too
         case (addr)
            TPM_ADDR_OUT_SEL: out_sel_reg <= wdata[7:0];
            TPM_ADDR_SCALE_HI1: scale_hi_reg[0] <= wdata[15:0];
            TPM_ADDR_SCALE_LO1: scale_lo_reg[0] <= wdata[15:0];
            TPM_ADDR_SCALE_HI2: scale_hi_reg[1] <= wdata[15:0];
            TPM_ADDR_SCALE_LO2: scale_lo_reg[1] <= wdata[15:0];
            TPM_ADDR_POINT: point_reg <= wdata[3:0];
            default: ;
         endcase
      end
   end

   // =========================================================
   // control configuration and stop-time MV
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_mode_reg <= TPM_PON_CONTINUE;
         onoff_reg <= 1'b0;
         mv_stop_reg <= TPM_MV_STOP_RST;
      end else if (state_reg == TPM_BOOT) begin
         // stored selector is caught after reset release
         cfg_mode_reg <= nv_power_on_mode;
      end else if (wr_en && addr == TPM_ADDR_CTRL && !run_reg) begin
         // writes while running are dropped to protect the
         // unit from a host that ignores the stop condition
         cfg_mode_reg <= wdata[1:0];
         onoff_reg <= wdata[TPM_CTRL_ONOFF];
      end else if (wr_en && addr == TPM_ADDR_MV_STOP) begin
         mv_stop_reg <= wdata[15:0];
      end
   end

   // =========================================================
   // restart sequencer: boot, apply selector, operate
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= TPM_BOOT;
         boot_reg <= 1'b1;
         apply_reg <= 1'b0;
         active_mode_reg <= TPM_PON_CONTINUE;
      end else begin
         apply_reg <= 1'b0;
         unique case (state_reg)
            TPM_BOOT: begin
               state_reg <= TPM_APPLY;
               boot_reg <= 1'b1;
            end
            TPM_APPLY: begin
               // the selector is frozen only here, so a later
               // write waits for the next restart
               active_mode_reg <= cfg_mode_reg;
               apply_reg <= 1'b1;
               state_reg <= TPM_OPER;
            end
            TPM_OPER: begin
               if (soft_reset) begin
                  state_reg <= TPM_APPLY;
                  boot_reg <= 1'b0;
               end
            end
         endcase
      end
   end

   // =========================================================
   // decision table for the restart state
   tpm_powerup u_powerup (
      .clk(clk),
      .reset_n(reset_n),
      .apply(apply_reg),
      .mode(active_mode_reg),
      .onoff(onoff_reg),
      .prev_run(boot_reg ? retained_run : run_reg),
      .prev_manual(boot_reg ? retained_manual : manual_reg),
      .prev_mv(boot_reg ? retained_mv : mv_reg),
      .mv_at_stop(mv_stop_reg),
      .init_valid(init_valid),
      .init_run(init_run),
      .init_manual(init_manual),
      .init_mv(init_mv)
   );

   // =========================================================
   // run/stop: restart result, then command or event edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         run_reg <= 1'b0;
      end else if (init_valid) begin
         run_reg <= init_run;
      end else if (state_reg == TPM_OPER) begin
         // stop wins when both sources ask at once
         if (cmd_stop || ev_fall) begin
            run_reg <= 1'b0;
         end else if (cmd_run || ev_rise) begin
            run_reg <= 1'b1;
         end
      end
   end

   // =========================================================
   // auto/manual and the held manipulated variable
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         manual_reg <= 1'b0;
         mv_reg <= TPM_MV_ZERO;
      end else if (init_valid) begin
         manual_reg <= init_manual;
         mv_reg <= init_mv;
      end else if (state_reg == TPM_OPER) begin
         if (cmd_wr && wdata[TPM_CMD_MANUAL] && !onoff_reg) begin
            manual_reg <= 1'b1;
         end else if (cmd_wr && wdata[TPM_CMD_AUTO]) begin
            manual_reg <= 1'b0;
         end
         // manual MV comes from the host, auto tracks mv_heat while running and takes the stop MV while stopped
         if (manual_reg) begin
            if (wr_en && addr == TPM_ADDR_MV_MANUAL) begin
               mv_reg <= wdata[15:0];
            end
         end else if (run_reg) begin
            mv_reg <= mv_heat;
         end else begin
            mv_reg <= mv_stop_reg;
         end
      end
   end

   // =========================================================
   // per-output source selection and scaling
   generate
      for (genvar i = 0; i < 2; i++) begin : g_out
         logic [2:0] sel;
         logic is_ctrl;
         assign sel = out_sel_reg[i*TPM_SEL_STRIDE +: 3];
         // control kinds overdrive the top endpoint, and the bottom one only in the 4-20 mA range
         assign is_ctrl = (sel == TPM_SRC_CTRL_HEAT)
            || (sel == TPM_SRC_CTRL_COOL);

         always_comb begin
            unique case (sel)
               TPM_SRC_XFER_HEAT: src_val[i] = mv_heat;
               TPM_SRC_CTRL_HEAT: src_val[i] = mv_heat;
               TPM_SRC_XFER_COOL: src_val[i] = mv_cool;
               TPM_SRC_CTRL_COOL: src_val[i] = mv_cool;
               TPM_SRC_PV: src_val[i] = pv;
               TPM_SRC_TARGET: src_val[i] = internal_target;
               TPM_SRC_LOCAL_SP: src_val[i] = local_sp;
               TPM_SRC_REMOTE_SP: src_val[i] = remote_sp;
            endcase
         end

         tpm_scaler u_scaler (
            .clk(clk),
            .reset_n(reset_n),
            .src(src_val[i]),
            .scale_hi(scale_hi_reg[i]),
            .scale_lo(scale_lo_reg[i]),
            .is_ctrl(is_ctrl),
            .range_0_20(out_sel_reg[i*TPM_SEL_STRIDE+TPM_SEL_RANGE]),
            .current_ua(cur_ua[i])
         );
      end
   endgenerate

   assign out1_current_ua = cur_ua[0];
   assign out2_current_ua = cur_ua[1];

   // =========================================================
   // state outputs, each straight from its register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         run_state <= 1'b0;
         manual_state <= 1'b0;
         mv_value <= TPM_MV_ZERO;
      end else begin
         run_state <= run_reg;
         manual_state <= manual_reg;
         mv_value <= mv_reg;
      end
   end

   // =========================================================
   // read port: data stand the cycle after the strobe
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 32'h0000_0000;
      end else if (rd_en) begin
         case (addr)
            TPM_ADDR_OUT_SEL: rdata <= {24'h0, out_sel_reg};
            TPM_ADDR_SCALE_HI1: rdata <= {16'h0, scale_hi_reg[0]};
            TPM_ADDR_SCALE_LO1: rdata <= {16'h0, scale_lo_reg[0]};
            TPM_ADDR_SCALE_HI2: rdata <= {16'h0, scale_hi_reg[1]};
            TPM_ADDR_SCALE_LO2: rdata <= {16'h0, scale_lo_reg[1]};
            TPM_ADDR_POINT: rdata <= {28'h0, point_reg};
            TPM_ADDR_CTRL: rdata <= {29'h0, onoff_reg, cfg_mode_reg};
            TPM_ADDR_MV_STOP: rdata <= {16'h0, mv_stop_reg};
            TPM_ADDR_STATUS:
               rdata <= {28'h0, active_mode_reg, manual_reg, run_reg};
            TPM_ADDR_MV: rdata <= {16'h0, mv_reg};
            default: rdata <= 32'h0000_0000; // unmapped reads zero
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end
endmodule // tpm_top

// ==== src/tpm_pkg.sv ====
package tpm_pkg;

   // =========================================================
   // register byte addresses
   localparam logic [7:0] TPM_ADDR_OUT_SEL = 8'h00;
   localparam logic [7:0] TPM_ADDR_SCALE_HI1 = 8'h04;
   localparam logic [7:0] TPM_ADDR_SCALE_LO1 = 8'h08;
   localparam logic [7:0] TPM_ADDR_SCALE_HI2 = 8'h0C;
   localparam logic [7:0] TPM_ADDR_SCALE_LO2 = 8'h10;
   localparam logic [7:0] TPM_ADDR_POINT = 8'h14;
   localparam logic [7:0] TPM_ADDR_CTRL = 8'h18;
   localparam logic [7:0] TPM_ADDR_CMD = 8'h1C;
   localparam logic [7:0] TPM_ADDR_MV_STOP = 8'h20;
   localparam logic [7:0] TPM_ADDR_MV_MANUAL = 8'h24;
   localparam logic [7:0] TPM_ADDR_STATUS = 8'h28;
   localparam logic [7:0] TPM_ADDR_MV = 8'h2C;

   // =========================================================
   // field positions
   localparam int TPM_SEL_STRIDE = 4;   // per output: src[2:0], range[3]
   localparam int TPM_SEL_RANGE = 3;
   localparam int TPM_CTRL_ONOFF = 2;   // mode in [1:0]
   localparam int TPM_CMD_RUN = 0;
   localparam int TPM_CMD_STOP = 1;
   localparam int TPM_CMD_AUTO = 2;
   localparam int TPM_CMD_MANUAL = 3;
   localparam int TPM_CMD_SOFT_RESET = 4;
   localparam int TPM_ST_RUN = 0;
   localparam int TPM_ST_MANUAL = 1;
   localparam int TPM_ST_MODE = 2;      // active mode in [3:2]

   // =========================================================
   // reset values
   localparam logic [15:0] TPM_SCALE_HI_RST = 16'h0064;  // 100
   localparam logic [15:0] TPM_SCALE_LO_RST = 16'h0000;
   localparam logic [15:0] TPM_MV_STOP_RST = 16'h0000;

   // =========================================================
   // source codes of an output assignment
   localparam logic [2:0] TPM_SRC_XFER_HEAT = 3'h0;
   localparam logic [2:0] TPM_SRC_XFER_COOL = 3'h1;
   localparam logic [2:0] TPM_SRC_CTRL_HEAT = 3'h2;
   localparam logic [2:0] TPM_SRC_CTRL_COOL = 3'h3;
   localparam logic [2:0] TPM_SRC_PV = 3'h4;
   localparam logic [2:0] TPM_SRC_TARGET = 3'h5;
   localparam logic [2:0] TPM_SRC_LOCAL_SP = 3'h6;
   localparam logic [2:0] TPM_SRC_REMOTE_SP = 3'h7;

   // power-on behaviour codes
   localparam logic [1:0] TPM_PON_CONTINUE = 2'h0;
   localparam logic [1:0] TPM_PON_STOP = 2'h1;
   localparam logic [1:0] TPM_PON_MANUAL = 2'h2;

   // =========================================================
   // current endpoints in microamps
   localparam logic [15:0] TPM_UA_4MA0 = 16'h0FA0;   // 4000
   localparam logic [15:0] TPM_UA_3MA7 = 16'h0E74;   // 3700
   localparam logic [15:0] TPM_UA_20MA0 = 16'h4E20;  // 20000
   localparam logic [15:0] TPM_UA_20MA3 = 16'h4F4C;  // 20300
   localparam logic [15:0] TPM_UA_0MA0 = 16'h0000;

   // manipulated variable in tenths of a percent
   localparam logic [15:0] TPM_MV_ZERO = 16'h0000;
   localparam logic [15:0] TPM_MV_FULL = 16'h03E8;   // 100.0 %

   // start-up sequencer states
   typedef enum logic [2:0] {
      TPM_BOOT = 3'b001,
      TPM_APPLY = 3'b010,
      TPM_OPER = 3'b100
   } tpm_state_t;

endpackage

// ==== src/tpm_scaler.sv ====
`timescale 1ns/1ps
// =========================================================
// scale one source value into an output current
module tpm_scaler import tpm_pkg::*; (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic signed [15:0] src,
   input wire logic signed [15:0] scale_hi,
   input wire logic signed [15:0] scale_lo,
   input wire logic is_ctrl,
   input wire logic range_0_20,
   output logic [15:0] current_ua
);
   logic signed [16:0] num_s; // source above lower limit
   logic signed [16:0] den_s; // limit span, made positive
   logic [15:0] base; // current at 0 %
   logic [15:0] top; // current at 100 %
   logic [15:0] span;
   logic [32:0] prod;
   logic [32:0] quot;
   logic [15:0] current_next;

   // endpoint choice by range and assignment kind
   always_comb begin
      if (range_0_20) begin
         base = TPM_UA_0MA0;
         top = is_ctrl ? TPM_UA_20MA3 : TPM_UA_20MA0;
      end else begin
         base = is_ctrl ? TPM_UA_3MA7 : TPM_UA_4MA0;
         top = is_ctrl ? TPM_UA_20MA3 : TPM_UA_20MA0;
      end
      span = top - base;
   end

   // linear map; a falling span is folded so the current falls
   always_comb begin
      num_s = {src[15], src} - {scale_lo[15], scale_lo};
      den_s = {scale_hi[15], scale_hi} - {scale_lo[15], scale_lo};
      if (den_s < 0) begin
         num_s = -num_s;
         den_s = -den_s;
      end
      prod = 33'(num_s[15:0]) * 33'(span);
      quot = (den_s == 0) ? 33'h0 : prod / 33'(den_s[15:0]);
      if (den_s == 0 || num_s <= 0) begin
         current_next = base;
      end else if (num_s >= den_s) begin
         current_next = top;
      end else begin
         current_next = base + quot[15:0];
      end
   end

   // registered so the drive never glitches
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         current_ua <= TPM_UA_0MA0;
      end else begin
         current_ua <= current_next;
      end
   end
endmodule // tpm_scaler

// ==== src/tpm_powerup.sv ====
`timescale 1ns/1ps
// =========================================================
// work out run, manual and MV after a restart
module tpm_powerup import tpm_pkg::*; (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic apply,
   input wire logic [1:0] mode,
   input wire logic onoff,
   input wire logic prev_run,
   input wire logic prev_manual,
   input wire logic [15:0] prev_mv,
   input wire logic [15:0] mv_at_stop,
   output logic init_valid,
   output logic init_run,
   output logic init_manual,
   output logic [15:0] init_mv
);
   logic run_next;
   logic manual_next;
   logic [15:0] mv_next;
   logic [15:0] held_mv; // manual keeps its MV, auto uses stop MV

   // decision table per selected behaviour
   always_comb begin
      held_mv = prev_manual ? prev_mv : mv_at_stop;
      case (mode)
         TPM_PON_STOP: begin
            run_next = 1'b0;
            manual_next = onoff ? 1'b0 : prev_manual;
            mv_next = onoff ? TPM_MV_ZERO : held_mv;
         end
         TPM_PON_MANUAL: begin
            run_next = prev_run;
            manual_next = 1'b1;
            mv_next = held_mv;
         end
         default: begin
            // continue; code 3 is illegal and falls back here
            run_next = prev_run;
            manual_next = onoff ? 1'b0 : prev_manual;
            if (onoff) begin
               mv_next = (prev_mv != TPM_MV_ZERO) ? TPM_MV_FULL
                  : TPM_MV_ZERO;
            end else begin
               mv_next = prev_mv;
            end
         end
      endcase
   end

   // result stands one cycle after apply
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         init_valid <= 1'b0;
         init_run <= 1'b0;
         init_manual <= 1'b0;
         init_mv <= TPM_MV_ZERO;
      end else begin
         init_valid <= apply;
         if (apply) begin
            init_run <= run_next;
            init_manual <= manual_next;
            init_mv <= mv_next;
         end
      end
   end
endmodule // tpm_powerup

// ==== dv/tpm_loop_rx.sv ====
`timescale 1ns/1ps
// ==========================================
// loop receiver at the far end of one output
module tpm_loop_rx import tpm_pkg::*; (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [15:0] loop_ua,
   output logic [15:0] reading_ua,
   output logic open_loop
);
   // one sample per clock; a real input filters, which hides steps
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reading_ua <= 16'h0000;
         open_loop <= 1'b1;
      end else begin
         reading_ua <= loop_ua;
         // below the lowest overdrive level the loop looks broken
         open_loop <= (loop_ua < TPM_UA_3MA7);
      end
   end
endmodule // tpm_loop_rx

// ==== dv/tpm_top_asserts.sv ====
`timescale 1ns/1ps
// ==========================================
// checks on the top ports
module tpm_top_asserts import tpm_pkg::*; (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] addr,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [31:0] rdata,
   input wire logic event_run_pin,
   input wire logic [1:0] nv_power_on_mode,
   input wire logic retained_run,
   input wire logic [15:0] out1_current_ua,
   input wire logic [15:0] out2_current_ua,
   input wire logic run_state,
   input wire logic manual_state
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // pin edge, then the pin held with no bus writes
   sequence pin_up_s;
      $rose(event_run_pin) ##1 (event_run_pin && !wr_en)[*7];
   endsequence
   sequence pin_down_s;
      $fell(event_run_pin) ##1 (!event_run_pin && !wr_en)[*7];
   endsequence
   rdata_idle_a: assert property (!rd_en |=> rdata == 32'h0)
      else $error("read data not zero outside a read");
   unmapped_read_a: assert property (rd_en && (addr > 8'h2C ||
      addr[1:0] != 2'h0) |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   reset_clear_a: assert property ($rose(reset_n) |->
      !run_state && !manual_state && out1_current_ua == 16'h0)
      else $error("state not clear after reset");
   stop_powerup_a: assert property ($rose(reset_n) &&
      nv_power_on_mode == TPM_PON_STOP |-> (!run_state)[*8])
      else $error("stop power-up came up running");
   manual_powerup_a: assert property ($rose(reset_n) &&
      nv_power_on_mode == TPM_PON_MANUAL |-> ##[2:8] manual_state)
      else $error("manual power-up not manual");
   keep_run_a: assert property ($rose(reset_n) &&
      nv_power_on_mode == TPM_PON_CONTINUE |->
      ##[2:8] run_state == retained_run)
      else $error("continue power-up lost run state");
   out1_ceiling_a: assert property (out1_current_ua <= TPM_UA_20MA3)
      else $error("output 1 above top endpoint");
   out2_ceiling_a: assert property (out2_current_ua <= TPM_UA_20MA3)
      else $error("output 2 above top endpoint");
   pin_run_a: assert property (pin_up_s |-> ##[0:3] run_state)
      else $error("event pin did not start control");
   pin_stop_a: assert property (pin_down_s |-> ##[0:3] !run_state)
      else $error("event pin did not stop control");
endmodule // tpm_top_asserts
bind tpm_top tpm_top_asserts tpm_top_asserts_inst (.clk(clk),
   .reset_n(reset_n), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
   .rdata(rdata), .event_run_pin(event_run_pin),
   .nv_power_on_mode(nv_power_on_mode), .retained_run(retained_run),
   .out1_current_ua(out1_current_ua), .out2_current_ua(out2_current_ua),
   .run_state(run_state), .manual_state(manual_state));

// ==== dv/tpm_top_tb.sv ====
`timescale 1ns/1ps
// ==========================================
// bench: power-up table, output scaling, run and stop
module tpm_top_tb;
   import tpm_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [31:0] rdata;
   logic signed [15:0] pv = 16'h0, tgt = 16'h0, lsp = 16'h0;
   logic signed [15:0] rsp = 16'h0, mv_heat = 16'h0, mv_cool = 16'h0;
   logic event_run_pin = 1'b0;
   logic [1:0] nv_power_on_mode = 2'h0;
   logic retained_run = 1'b0;
   logic retained_manual = 1'b0;
   logic [15:0] retained_mv = 16'h0;
   logic [15:0] out1, out2, rx1, rx2, mv_value;
   logic run_state, manual_state;
   int mismatches = 0;
   int checked = 0;
   always #2.5 clk = ~clk;
   tpm_top tpm_top_inst (.clk(clk), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .pv(pv), .internal_target(tgt), .local_sp(lsp), .remote_sp(rsp),
      .mv_heat(mv_heat), .mv_cool(mv_cool), .event_run_pin(event_run_pin),
      .nv_power_on_mode(nv_power_on_mode), .retained_run(retained_run),
      .retained_manual(retained_manual), .retained_mv(retained_mv),
      .out1_current_ua(out1), .out2_current_ua(out2),
      .run_state(run_state), .manual_state(manual_state),
      .mv_value(mv_value));
   tpm_loop_rx tpm_loop_rx_inst (.clk(clk), .reset_n(reset_n),
      .loop_ua(out1), .reading_ua(rx1), .open_loop());
   tpm_loop_rx tpm_loop_rx_inst2 (.clk(clk), .reset_n(reset_n),
      .loop_ua(out2), .reading_ua(rx2), .open_loop());
   // ==========================================
   // bus tasks and checks
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask
   task cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %0h seen %0h", what, e, g);
      end
   endtask
   // drive one source code, every other source at zero
   task set_src(input int c, input int v);
      @(posedge clk);
      mv_heat <= (c == 0 || c == 2) ? 16'(v) : 16'h0;
      mv_cool <= (c == 1 || c == 3) ? 16'(v) : 16'h0;
      pv <= (c == 4) ? 16'(v) : 16'h0;
      tgt <= (c == 5) ? 16'(v) : 16'h0;
      lsp <= (c == 6) ? 16'(v) : 16'h0;
      rsp <= (c == 7) ? 16'(v) : 16'h0;
   endtask
   // limits 100 and 0 (reversed when rev) in microamps
   function automatic int exp_cur(int c, int rng, int rev, int v);
      int lo, hi, p;
      hi = (c == 2 || c == 3) ? int'(TPM_UA_20MA3) : int'(TPM_UA_20MA0);
      lo = (c == 2 || c == 3) ? int'(TPM_UA_3MA7) : int'(TPM_UA_4MA0);
      if (rng != 0) lo = int'(TPM_UA_0MA0);
      p = (v < 0) ? 0 : (v > 100) ? 100 : v;
      if (rev != 0) p = 100 - p;
      return lo + (hi - lo) * p / 100;
   endfunction
   task close_out;
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      close_out;
   end
   // ==========================================
   // main sequence
   initial begin
      int rmv;
      int vals[5];
      logic [31:0] d;
      void'($urandom(32'hE659));
      // selector codes 0 to 2 against every retained state
      for (int m = 0; m < 3; m++) for (int k = 0; k < 4; k++) begin
         rmv = $urandom_range(1, 1000);
         @(posedge clk);
         reset_n <= 1'b0;
         nv_power_on_mode <= 2'(m);
         retained_run <= k[0];
         retained_manual <= k[1];
         retained_mv <= 16'(rmv);
         mv_heat <= 16'(rmv);
         repeat (3) @(posedge clk);
         reset_n <= 1'b1;
         repeat (8) @(posedge clk);
         #1 cmp("run", (m == 1) ? 0 : k[0], run_state);
         cmp("manual", (m == 2) ? 1 : k[1], manual_state);
         cmp("mv", (!k[1] && (m != 0 || !k[0])) ? 0 : rmv, mv_value);
         rd(TPM_ADDR_STATUS, d);
         cmp("selector", m, d[3:2]);
      end
      wr(TPM_ADDR_SCALE_HI2, 32'h0);
      wr(TPM_ADDR_SCALE_LO2, 32'h64);
      for (int c = 0; c < 8; c++) for (int r = 0; r < 2; r++) begin
         wr(TPM_ADDR_OUT_SEL, 32'((r * 8 + c) * 17));
         vals = '{0, 50, 100, -int'($urandom_range(1, 1999)),
            int'($urandom_range(101, 9999))};
         foreach (vals[i]) begin
            set_src(c, vals[i]);
            repeat (4) @(posedge clk);
            #1 cmp("out1", exp_cur(c, r, 0, vals[i]), rx1);
            cmp("out2", exp_cur(c, r, 1, vals[i]), rx2);
         end
      end
      // stop, run, both at once (stop wins); the pin comes after the manual restart
      foreach (vals[i]) vals[i] = (i == 1) ? 1 : (i == 2) ? 3 : 2;
      for (int i = 0; i < 3; i++) begin
         wr(TPM_ADDR_CMD, 32'(vals[i]));
         repeat (3) @(posedge clk);
         #1 cmp("command", (i == 1) ? 1 : 0, run_state);
      end
      // manual restart after an auto run starts from stop-time MV
      wr(TPM_ADDR_MV_STOP, 32'h1F4);
      wr(TPM_ADDR_CMD, 32'h5);
      wr(TPM_ADDR_CMD, 32'h10);
      repeat (5) @(posedge clk);
      #1 cmp("manual restart", 1, manual_state);
      cmp("manual run kept", 1, run_state);
      cmp("stop-time mv", 32'h1F4, mv_value);
      wr(TPM_ADDR_MV_STOP, 32'h0);
      for (int e = 1; e >= 0; e--) begin
         @(posedge clk);
         event_run_pin <= e[0];
         repeat (8) @(posedge clk);
         #1 cmp("pin", e, run_state);
      end
      // on/off, stop selector written while stopped, then run
      wr(TPM_ADDR_CTRL, 32'h5);
      wr(TPM_ADDR_CMD, 32'h1);
      rd(TPM_ADDR_STATUS, d);
      cmp("held selector", 2, d[3:2]);
      wr(TPM_ADDR_CMD, 32'h10);
      repeat (5) @(posedge clk);
      #1 cmp("onoff run", 0, run_state);
      cmp("onoff manual", 0, manual_state);
      cmp("onoff mv", 0, mv_value);
      rd(TPM_ADDR_STATUS, d);
      cmp("new selector", 1, d[3:2]);
      wr(TPM_ADDR_CTRL, 32'h4);
      wr(TPM_ADDR_CMD, 32'h1);
      wr(TPM_ADDR_CMD, 32'h10);
      repeat (5) @(posedge clk);
      #1 cmp("continue run", 1, run_state);
      cmp("continue mv", 0, mv_value);
      rd(8'h40, d);
      cmp("unmapped", 0, d);
      close_out;
   end
endmodule // tpm_top_tb
